/* File: hdl/scl_control_low.sv */
// Buffered decoder for the low fourteen bits of control_function_one.
// -----------------------------------------------------------------------------
// Summary of operation
// - Destination 00 gives frequency keying or frequency sweep; software keeps 00 in modulus mode.
// - Destination 01 gives phase keying or routes the accumulator to phase sweep.
// - The enable bit runs the auxiliary accumulator; while clear, linear sweep is off.
// - With sweep on, the DC bit forces the DAC to full scale and disables the synth output.
// - The trigger bit picks edge triggering when clear and level triggering when set.
// - No-dwell clear holds the final sweep value, set returns to the start; ignored without sweep.
// - Fast power-down mode: a high pin stops only the digital logic and DAC digital logic.
// - Full power-down mode: a high pin stops every function including the DAC and PLL.
// - The digital power-down bit parks the digital core in low dissipation.
// - The DAC power-down bit puts the DAC in its lowest power state.
// - The clock input power-down bit stops clock generation only; the PLL and oscillator keep running.
// - With load bit clear, a new sweep rate enters the timer only when the period expires.
// - With load bit set, the timer is reloaded at once on the update strobe.
// - Auxiliary autoclear loads zero into the auxiliary accumulator for one cycle per update.
// - Phase autoclear clears the phase accumulator for one cycle per update.
// - The waveform bit picks cosine when clear and sine when set.
// - Written bits wait in a buffer and reach the logic only on the update strobe.
// -----------------------------------------------------------------------------
module scl_control_low
  import scl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic io_update,
  input wire logic power_down_pin,
  output logic [31:0] rd_data_q,
  output logic freq_dest_q,
  output logic phase_dest_q,
  output logic aux_acc_run_q,
  output logic dac_full_scale_q,
  output logic synth_out_disable_q,
  output logic level_trigger_q,
  output logic no_dwell_q,
  output logic core_pd_q,
  output logic dac_digital_pd_q,
  output logic dac_pd_q,
  output logic pll_pd_q,
  output logic osc_pd_q,
  output logic clk_gen_pd_q,
  output logic aux_acc_clear_q,
  output logic phase_acc_clear_q,
  output logic sine_select_q,
  output logic ramp_tick
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic upd_s1_q;
  logic upd_s2_q;
  logic upd_s3_q;
  logic pd_s1_q;
  logic pd_s2_q;
  logic upd_pulse;

  // Both pins come from outside, so each passes two flops before use.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      upd_s1_q <= 1'b0;
      upd_s2_q <= 1'b0;
      upd_s3_q <= 1'b0;
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
    end
    else
    begin
      upd_s1_q <= io_update;
      upd_s2_q <= upd_s1_q;
      upd_s3_q <= upd_s2_q;
      pd_s1_q <= power_down_pin;
      pd_s2_q <= pd_s1_q;
    end
  end

  // A long strobe still counts once: only its rising edge transfers.
  assign upd_pulse = upd_s2_q & ~upd_s3_q;

  // ---------------------------------------------------------------------------
  // Write buffer and active copies
  // ---------------------------------------------------------------------------
  logic [FIELD_W-1:0] buf_q;
  logic [FIELD_W-1:0] buf_d;
  logic [FIELD_W-1:0] act_q;
  logic [FIELD_W-1:0] act_d;
  logic [SRR_W-1:0] srr_buf_q;
  logic [SRR_W-1:0] srr_buf_d;
  logic [SRR_W-1:0] srr_act_q;
  logic [SRR_W-1:0] srr_act_d;
  logic reload_q;
  logic reload_d;
  logic [31:0] rd_data_d;

  // Writes only touch the buffer; the running copy changes on update so a
  // multi-byte program sequence never shows a half-written word.
  always_comb
  begin
    buf_d = buf_q;
    srr_buf_d = srr_buf_q;
    act_d = act_q;
    srr_act_d = srr_act_q;
    rd_data_d = DATA_ZERO;
    if (wr_en && wr_addr == CTRL_ONE_ADDR)
    begin
      buf_d = wr_data[FIELD_W-1:0];
    end
    if (wr_en && wr_addr == SWEEP_RATE_ADDR)
    begin
      srr_buf_d = wr_data[SRR_W-1:0];
    end
    if (upd_pulse)
    begin
      act_d = buf_q;
      srr_act_d = srr_buf_q;
    end
    // The timer sees the new rate one cycle after the update, together
    // with the reload request.
    reload_d = upd_pulse & buf_q[LOAD_SRR_BIT];
    if (rd_addr == CTRL_ONE_ADDR)
    begin
      rd_data_d[FIELD_W-1:0] = buf_q;
    end
    else if (rd_addr == SWEEP_RATE_ADDR)
    begin
      rd_data_d[SRR_W-1:0] = srr_buf_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      buf_q <= CTRL_ONE_RESET;
      act_q <= CTRL_ONE_RESET;
      srr_buf_q <= SRR_RESET;
      srr_act_q <= SRR_RESET;
      reload_q <= 1'b0;
      rd_data_q <= DATA_ZERO;
    end
    else
    begin
      buf_q <= buf_d;
      act_q <= act_d;
      srr_buf_q <= srr_buf_d;
      srr_act_q <= srr_act_d;
      reload_q <= reload_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  logic sweep_on;
  logic full_pd;
  logic freq_dest_d;
  logic phase_dest_d;
  logic dac_full_scale_d;
  logic level_trigger_d;
  logic no_dwell_d;
  logic core_pd_d;
  logic dac_digital_pd_d;
  logic dac_pd_d;
  logic pll_pd_d;
  logic osc_pd_d;
  logic clk_gen_pd_d;
  logic aux_clear_d;
  logic phase_clear_d;
  logic sine_d;

  assign sweep_on = act_q[AUX_EN_BIT];
  assign full_pd = pd_s2_q & act_q[EXT_PD_MODE_BIT];

  // Sweep-only bits are masked by the enable so that a stale DC or dwell
  // setting cannot leak out once the accumulator is switched off.
  always_comb
  begin
    freq_dest_d = act_q[DEST_HI:DEST_LO] == DEST_FREQ;
    phase_dest_d = act_q[DEST_HI:DEST_LO] == DEST_PHASE;
    dac_full_scale_d = act_q[DC_OUT_BIT] & sweep_on;
    level_trigger_d = act_q[TRIG_BIT];
    no_dwell_d = act_q[NO_DWELL_BIT] & sweep_on;
    core_pd_d = act_q[DIG_PD_BIT] | pd_s2_q;
    dac_digital_pd_d = act_q[DAC_PD_BIT] | pd_s2_q;
    dac_pd_d = act_q[DAC_PD_BIT] | full_pd;
    pll_pd_d = full_pd;
    osc_pd_d = full_pd;
    clk_gen_pd_d = act_q[CLK_PD_BIT] | full_pd;
    aux_clear_d = upd_pulse & buf_q[AUTOCLR_AUX_BIT];
    phase_clear_d = upd_pulse & buf_q[AUTOCLR_PHASE_BIT];
    sine_d = act_q[SINE_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      freq_dest_q <= 1'b0;
      phase_dest_q <= 1'b0;
      aux_acc_run_q <= 1'b0;
      dac_full_scale_q <= 1'b0;
      synth_out_disable_q <= 1'b0;
      level_trigger_q <= 1'b0;
      no_dwell_q <= 1'b0;
      core_pd_q <= 1'b0;
      dac_digital_pd_q <= 1'b0;
      dac_pd_q <= 1'b0;
      pll_pd_q <= 1'b0;
      osc_pd_q <= 1'b0;
      clk_gen_pd_q <= 1'b0;
      aux_acc_clear_q <= 1'b0;
      phase_acc_clear_q <= 1'b0;
      sine_select_q <= 1'b0;
    end
    else
    begin
      freq_dest_q <= freq_dest_d;
      phase_dest_q <= phase_dest_d;
      aux_acc_run_q <= sweep_on;
      dac_full_scale_q <= dac_full_scale_d;
      synth_out_disable_q <= dac_full_scale_d;
      level_trigger_q <= level_trigger_d;
      no_dwell_q <= no_dwell_d;
      core_pd_q <= core_pd_d;
      dac_digital_pd_q <= dac_digital_pd_d;
      dac_pd_q <= dac_pd_d;
      pll_pd_q <= pll_pd_d;
      osc_pd_q <= osc_pd_d;
      clk_gen_pd_q <= clk_gen_pd_d;
      aux_acc_clear_q <= aux_clear_d;
      phase_acc_clear_q <= phase_clear_d;
      sine_select_q <= sine_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Ramp-rate timer
  // ---------------------------------------------------------------------------
  // The tick leaves straight from the timer's own flop.
  scl_ramp_timer u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(sweep_on),
    .reload_now(reload_q),
    .rate(srr_act_q),
    .tick_q(ramp_tick)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // The clear must rise on the edge after the update pulse and drop again at once.
  sequence s_aux_clear_once;
    aux_acc_clear_q ##1 !aux_acc_clear_q;
  endsequence

  AST_TRANSFER_ON_UPDATE: assert property (
    upd_pulse |=> act_q == $past(buf_q))
    else $error("Buffered field did not transfer on update.");

  AST_HOLD_WITHOUT_UPDATE: assert property (
    !upd_pulse |=> act_q == $past(act_q))
    else $error("Active fields changed without update.");

  AST_DC_FULL_SCALE: assert property (
    act_q[DC_OUT_BIT] && sweep_on |=> dac_full_scale_q && synth_out_disable_q)
    else $error("DC output did not force full scale.");

  AST_DC_IGNORED: assert property (
    !sweep_on |=> !dac_full_scale_q && !no_dwell_q)
    else $error("Sweep-only bit acted with sweep off.");

  AST_FULL_POWER_DOWN: assert property (
    pd_s2_q && act_q[EXT_PD_MODE_BIT] |=> pll_pd_q && dac_pd_q && osc_pd_q && clk_gen_pd_q)
    else $error("Full power-down left a block running.");

  AST_FAST_POWER_DOWN: assert property (
    pd_s2_q && act_q[EXT_PD_MODE_BIT:CLK_PD_BIT] == 4'h0 |=>
      core_pd_q && dac_digital_pd_q && !pll_pd_q && !dac_pd_q && !clk_gen_pd_q)
    else $error("Fast power-down did not match its scope.");

  AST_AUX_CLEAR_PULSE: assert property (
    upd_pulse && buf_q[AUTOCLR_AUX_BIT] |=> s_aux_clear_once)
    else $error("Auxiliary autoclear was not a single cycle.");

  AST_PHASE_CLEAR_PULSE: assert property (
    upd_pulse |=> phase_acc_clear_q == $past(buf_q[AUTOCLR_PHASE_BIT]) ##1 !phase_acc_clear_q)
    else $error("Phase autoclear did not follow the update.");

  AST_DEST_DECODE: assert property (
    act_q[DEST_HI:DEST_LO] == DEST_PHASE |=> phase_dest_q && !freq_dest_q)
    else $error("Destination decode wrong.");

endmodule : scl_control_low

/* File: hdl/scl_pkg.sv */
// Constants shared by the low control field decoder and its ramp-rate timer.
package scl_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses on the programming port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
  localparam logic [7:0] SWEEP_RATE_ADDR = 8'h05;

  // ---------------------------------------------------------------------------
  // Field layout of control_function_one, low fourteen bits
  // ---------------------------------------------------------------------------
  localparam int FIELD_W = 14;
  localparam int DEST_HI = 13;
  localparam int DEST_LO = 12;
  localparam int AUX_EN_BIT = 11;
  localparam int DC_OUT_BIT = 10;
  localparam int TRIG_BIT = 9;
  localparam int NO_DWELL_BIT = 8;
  localparam int EXT_PD_MODE_BIT = 7;
  localparam int DIG_PD_BIT = 6;
  localparam int DAC_PD_BIT = 5;
  localparam int CLK_PD_BIT = 4;
  localparam int LOAD_SRR_BIT = 3;
  localparam int AUTOCLR_AUX_BIT = 2;
  localparam int AUTOCLR_PHASE_BIT = 1;
  localparam int SINE_BIT = 0;

  localparam logic [FIELD_W-1:0] CTRL_ONE_RESET = 14'h0000;
  localparam logic [1:0] DEST_FREQ = 2'h0;
  localparam logic [1:0] DEST_PHASE = 2'h1;

  // ---------------------------------------------------------------------------
  // Sweep rate register
  // ---------------------------------------------------------------------------
  localparam int SRR_W = 16;
  localparam logic [SRR_W-1:0] SRR_RESET = 16'h0001;
  localparam logic [SRR_W-1:0] SRR_ZERO = 16'h0000;
  localparam logic [SRR_W-1:0] SRR_ONE = 16'h0001;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : scl_pkg

/* File: hdl/scl_ramp_timer.sv */
// Ramp-rate timer that paces the auxiliary accumulator steps.
module scl_ramp_timer
  import scl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic reload_now,
  input wire logic [SRR_W-1:0] rate,
  output logic tick_q
);

  logic [SRR_W-1:0] count_q;
  logic [SRR_W-1:0] count_d;
  logic tick_d;

  // ---------------------------------------------------------------------------
  // Countdown
  // ---------------------------------------------------------------------------
  // A rate written without immediate reload is picked up only when the
  // running period expires, so a sweep in progress keeps its cadence.
  always_comb
  begin
    count_d = count_q;
    tick_d = 1'b0;
    if (!run)
    begin
      count_d = rate;
    end
    else if (reload_now)
    begin
      count_d = rate;
    end
    else if (count_q == SRR_ZERO)
    begin
      tick_d = 1'b1;
      count_d = rate;
    end
    else
    begin
      count_d = count_q - SRR_ONE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      count_q <= SRR_RESET;
      tick_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_IMMEDIATE_RELOAD: assert property (@(posedge ref_clk) disable iff (reset)
    run && reload_now |=> count_q == $past(rate) && !tick_q)
    else $error("Timer did not reload at once on update.");

  AST_LOAD_AT_EXPIRY: assert property (@(posedge ref_clk) disable iff (reset)
    run && !reload_now && count_q != SRR_ZERO |=> count_q == $past(count_q) - SRR_ONE)
    else $error("Timer was reloaded before its period expired.");

endmodule : scl_ramp_timer

/* File: verification/scl_control_low_tb.sv */
// Self-checking bench for the low control field decoder and its ramp timer.
module scl_control_low_tb;
  import scl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Signals, clock and design
  // ---------------------------------------------------------------------------
  typedef struct packed {logic [13:0] ctrl; logic pin; logic [13:0] exp;} scl_row_s;
  logic ref_clk, reset, wr_en, io_update, power_down_pin;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data_q;
  logic freq_dest_q, phase_dest_q, aux_acc_run_q, dac_full_scale_q, synth_out_disable_q;
  logic level_trigger_q, no_dwell_q, core_pd_q, dac_digital_pd_q, dac_pd_q, pll_pd_q;
  logic osc_pd_q, clk_gen_pd_q, aux_acc_clear_q, phase_acc_clear_q, sine_select_q;
  logic ramp_tick;
  logic [13:0] outs;
  int num_errors = 0;
  int total_checks = 0;
  int n_aux = 0;
  int n_ph = 0;
  int n;
  scl_row_s rows [0:8] = '{
    '{14'h0000, 1'b0, 14'h2000}, '{14'h1000, 1'b0, 14'h1000}, '{14'h3000, 1'b0, 14'h0000},
    '{14'h0F00, 1'b0, 14'h2F80}, '{14'h0700, 1'b0, 14'h2100}, '{14'h0071, 1'b0, 14'h2073},
    '{14'h0000, 1'b1, 14'h2060}, '{14'h0080, 1'b1, 14'h207E}, '{14'h0080, 1'b0, 14'h2000}};
  logic [13:0] clr_ctrl [0:2] = '{14'h0000, 14'h0006, 14'h0004};

  // Level outputs packed so one table column covers all of them.
  assign outs = {freq_dest_q, phase_dest_q, aux_acc_run_q, dac_full_scale_q,
    synth_out_disable_q, level_trigger_q, no_dwell_q, core_pd_q, dac_digital_pd_q,
    dac_pd_q, pll_pd_q, osc_pd_q, clk_gen_pd_q, sine_select_q};

  // Free-running 10 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Clear pulses are counted on every edge, so a pulse cannot slip between checks.
  always @(posedge ref_clk)
  begin
    if (aux_acc_clear_q === 1'b1) n_aux++;
    if (phase_acc_clear_q === 1'b1) n_ph++;
  end

  scl_control_low DUT (.ref_clk(ref_clk), .reset(reset), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .io_update(io_update),
    .power_down_pin(power_down_pin), .rd_data_q(rd_data_q), .freq_dest_q(freq_dest_q),
    .phase_dest_q(phase_dest_q), .aux_acc_run_q(aux_acc_run_q),
    .dac_full_scale_q(dac_full_scale_q), .synth_out_disable_q(synth_out_disable_q),
    .level_trigger_q(level_trigger_q), .no_dwell_q(no_dwell_q), .core_pd_q(core_pd_q),
    .dac_digital_pd_q(dac_digital_pd_q), .dac_pd_q(dac_pd_q), .pll_pd_q(pll_pd_q),
    .osc_pd_q(osc_pd_q), .clk_gen_pd_q(clk_gen_pd_q), .aux_acc_clear_q(aux_acc_clear_q),
    .phase_acc_clear_q(phase_acc_clear_q), .sine_select_q(sine_select_q),
    .ramp_tick(ramp_tick));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Every drive and sample happens 1 ns after the rising edge.
  task automatic cyc(input int k);
    repeat (k)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : cyc

  // The extra idle cycle keeps back-to-back writes from touching wr_en twice at once.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask : wr

  // Strobe long enough for the pin synchroniser, then let outputs settle.
  task automatic upd();
    io_update = 1'b1;
    cyc(3);
    io_update = 1'b0;
    cyc(8);
  endtask : upd

  // Counts cycles until the next tick is seen; bounded so a dead timer cannot hang.
  task automatic wait_tick(output int k);
    k = 0;
    while (ramp_tick !== 1'b1 && k < 1000)
    begin
      cyc(1);
      k++;
    end
  endtask : wait_tick

  task automatic chk_vec(input string nm, input logic [13:0] e, input logic [13:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  task automatic chk_word(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd_addr = a;
    cyc(2);
    total_checks++;
    if (rd_data_q !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, rd_data_q);
    end
  endtask : chk_word

  task automatic chk_cnt(input string nm, input int e, input int g);
    total_checks++;
    if (g != e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt

  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watchdog sized well above the roughly thirteen hundred cycles the tests take.
  initial
  begin
    #1000000;
    num_errors++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = DATA_ZERO;
    rd_addr = 8'h00;
    io_update = 1'b0;
    power_down_pin = 1'b0;
    cyc(20);
    chk_vec("in reset", 14'h0000, outs);
    reset = 1'b0;
    cyc(1);
    // Cleared fields decode as destination 00, so the frequency route is on at once.
    chk_vec("reset outputs", 14'h2000, outs);
    chk_word("reset rate", SWEEP_RATE_ADDR, 32'h0000_0001);
    // Written bits must stay parked in the buffer until a strobe arrives.
    wr(CTRL_ONE_ADDR, 32'hFFFF_CF71);
    wr(8'h3C, 32'hFFFF_FFFF);
    cyc(10);
    chk_vec("no strobe", 14'h2000, outs);
    chk_word("buffer read", CTRL_ONE_ADDR, 32'h0000_0F71);
    chk_word("unmapped read", 8'h3C, DATA_ZERO);
    $display("TEST done: reset and buffer");
    // Field table: each row is written, strobed and compared.
    for (int i = 0; i < 9; i++)
    begin
      wr(CTRL_ONE_ADDR, {18'h00000, rows[i].ctrl});
      power_down_pin = rows[i].pin;
      upd();
      chk_vec("decoded fields", rows[i].exp, outs);
    end
    $display("TEST done: field table");
    // Autoclear bits off, both on, auxiliary only.
    for (int i = 0; i < 3; i++)
    begin
      wr(CTRL_ONE_ADDR, {18'h00000, clr_ctrl[i]});
      n_aux = 0;
      n_ph = 0;
      upd();
      chk_cnt("aux clear pulses", int'(clr_ctrl[i][2]), n_aux);
      chk_cnt("phase clear pulses", int'(clr_ctrl[i][1]), n_ph);
    end
    $display("TEST done: autoclear");
    // Immediate reload mode: the rate takes hold on the strobe.
    wr(SWEEP_RATE_ADDR, 32'h0000_0003);
    wr(CTRL_ONE_ADDR, 32'h0000_0808);
    upd();
    wait_tick(n);
    cyc(1);
    wait_tick(n);
    chk_cnt("short gap", 3, n);
    wr(SWEEP_RATE_ADDR, 32'h0000_00C8);
    upd();
    wait_tick(n);
    cyc(1);
    wait_tick(n);
    chk_cnt("long gap", 200, n);
    cyc(20);
    wr(SWEEP_RATE_ADDR, 32'h0000_0003);
    upd();
    wait_tick(n);
    chk_cnt("early reload", 1, int'(n < 20));
    // Deferred mode: the running long period must finish first.
    wr(CTRL_ONE_ADDR, 32'h0000_0800);
    upd();
    wr(SWEEP_RATE_ADDR, 32'h0000_00C8);
    upd();
    wait_tick(n);
    cyc(1);
    wait_tick(n);
    chk_cnt("deferred long gap", 200, n);
    cyc(1);
    wr(SWEEP_RATE_ADDR, 32'h0000_0003);
    upd();
    wait_tick(n);
    chk_cnt("old period kept", 1, int'(n > 150));
    cyc(1);
    wait_tick(n);
    chk_cnt("new period", 3, n);
    $display("TEST done: ramp timer");
    // A second reset in mid-run must clear every decoded output.
    reset = 1'b1;
    cyc(2);
    chk_vec("held in reset", 14'h0000, outs);
    reset = 1'b0;
    cyc(1);
    chk_vec("second reset", 14'h2000, outs);
    chk_word("second reset rate", SWEEP_RATE_ADDR, 32'h0000_0001);
    $display("TEST done: second reset");
    stop_test();
  end

endmodule : scl_control_low_tb
